/* File: timer16_irq.sv */
// Summary of operation
// RL1: request needs flag, enable and global enable
// RL2: bits 7:6 and 4:3 read zero
// RL3: bit5 capture, bit2 cmpB, bit1 cmpA, bit0 ovf
// RL4: capture pin event sets capture flag
// RL5: capture-as-top mode: flag at top
// RL6: vector execution clears its flag
// RL7: writing one clears the flag
// RL8: writing zero leaves flags untouched
// RL9: compare flag set one tick after match
// RL10: forced compare strobe sets no flag
// RL11: overflow flag on wrap in normal, clear-on-match
// RL12: capture copies counter into capture register
//
// Implementation choice: the Avalon-MM register port.
module timer16_irq (
    // clock and reset
    input  wire logic                               REF_CLK_I,
    input  wire logic                               RESET_N_I,
    // avalon-mm slave
    input  wire timer16_irq_pkg::avs_req_t          AVS_I,
    output logic [31:0]                             AVS_READDATA_O,
    output logic                                    AVS_WAITREQUEST_O,
    // timer units, index 0 is unit 1, index 1 is unit 3
    input  wire timer16_irq_pkg::unit_in_t [1:0]    UNIT_I,
    input  wire logic [1:0][7:0]                    VEC_ACK_I,
    input  wire logic                               GIE_I,
    // requests and captured values
    output logic [1:0][7:0]                         IRQ_REQ_O,
    output logic [1:0][15:0]                        CAPTURE_REG_O,
    output logic                                    INT_O
);

    // ***********************************************
    // helpers
    // ***********************************************

    // modes in which the capture register is top
    function automatic logic icr_top(input logic [3:0] m);
        return m == timer16_irq_pkg::MODE_CTC_ICR
            || m == timer16_irq_pkg::MODE_PC_ICR
            || m == timer16_irq_pkg::MODE_PFC_ICR
            || m == timer16_irq_pkg::MODE_FST_ICR;
    endfunction

    // modes in which overflow is a plain wrap
    function automatic logic wrap_mode(input logic [3:0] m);
        return m == timer16_irq_pkg::MODE_NORMAL
            || m == timer16_irq_pkg::MODE_CTC_OCR
            || m == timer16_irq_pkg::MODE_CTC_ICR;
    endfunction

    // gated requests of one unit
    function automatic logic [7:0] req_of(input logic [7:0] f,
                                          input logic [7:0] m,
                                          input logic       g);
        return f & m & {8{g}};
    endfunction

    // ***********************************************
    // state and decode signals
    // ***********************************************
    timer16_irq_pkg::state_t s_reg;
    timer16_irq_pkg::state_t s_next;
    logic [1:0][7:0]         set_v;
    logic [1:0][7:0]         clr_v;
    logic [1:0]              mask_wr;
    logic [7:0]              idx;
    logic                    req;
    logic                    take;
    logic [7:0]              wbyte;

    assign idx   = AVS_I.address[timer16_irq_pkg::ADDR_W-1:
                                 timer16_irq_pkg::IDX_LSB];
    assign req   = AVS_I.read | AVS_I.write;
    assign take  = s_reg.bus == timer16_irq_pkg::BUS_ACK;
    assign wbyte = AVS_I.writedata[7:0];

    // ***********************************************
    // flag set events per unit
    // ***********************************************

    // force strobes never reach this path, only true equality
    always_comb
    begin
        set_v = '0;
        for (int u = 0; u < 2; u++)
        begin
            if (icr_top(UNIT_I[u].waveform_mode_sel))
            begin
                // pin is disconnected, flag marks top instead
                set_v[u][timer16_irq_pkg::CAPTURE_BIT] =
                    UNIT_I[u].tick
                    && UNIT_I[u].counter == s_reg.cap[u];   // RL5
            end
            else
            begin
                set_v[u][timer16_irq_pkg::CAPTURE_BIT] =
                    UNIT_I[u].cap_evt;                      // RL4
            end
            set_v[u][timer16_irq_pkg::CMPA_BIT] =
                UNIT_I[u].tick && s_reg.pend_a[u];          // RL9 RL10
            set_v[u][timer16_irq_pkg::CMPB_BIT] =
                UNIT_I[u].tick && s_reg.pend_b[u];          // RL9 RL10
            if (wrap_mode(UNIT_I[u].waveform_mode_sel))
            begin
                set_v[u][timer16_irq_pkg::OVF_BIT] =
                    UNIT_I[u].tick && UNIT_I[u].counter
                    == timer16_irq_pkg::COUNT_MAX;          // RL11
            end
            else
            begin
                // other modes: counter reports per its table
                set_v[u][timer16_irq_pkg::OVF_BIT] =
                    UNIT_I[u].ovf_evt;                      // RL11
            end
        end
    end

    // ***********************************************
    // bus write decode
    // ***********************************************

    // only ones clear; ack from the core clears as well
    always_comb
    begin
        clr_v   = VEC_ACK_I;                                // RL6
        mask_wr = '0;
        if (take && AVS_I.write)
        begin
            if (idx == timer16_irq_pkg::IDX_T1_FLAGS
                || idx == timer16_irq_pkg::IDX_T1_CLR)
            begin
                clr_v[0] = clr_v[0] | wbyte;                // RL7 RL8
            end
            else if (idx == timer16_irq_pkg::IDX_T3_FLAGS
                     || idx == timer16_irq_pkg::IDX_T3_CLR)
            begin
                clr_v[1] = clr_v[1] | wbyte;                // RL7 RL8
            end
            else if (idx == timer16_irq_pkg::IDX_T1_MASK)
            begin
                mask_wr[0] = 1'b1;
            end
            else if (idx == timer16_irq_pkg::IDX_T3_MASK)
            begin
                mask_wr[1] = 1'b1;
            end
        end
    end

    // ***********************************************
    // next state
    // ***********************************************
    always_comb
    begin
        s_next = s_reg;
        for (int u = 0; u < 2; u++)
        begin
            // set beats clear so no event is lost
            s_next.flags[u] = ((s_reg.flags[u] & ~clr_v[u])
                              | set_v[u])
                              & timer16_irq_pkg::IMPL_BITS; // RL2 RL3
            if (mask_wr[u])
            begin
                s_next.mask[u] = wbyte
                                 & timer16_irq_pkg::IMPL_BITS; // RL2
            end
            if (UNIT_I[u].tick)
            begin
                // remember the match until the next timer tick
                s_next.pend_a[u] = UNIT_I[u].counter
                                   == UNIT_I[u].cmp_a;      // RL9
                s_next.pend_b[u] = UNIT_I[u].counter
                                   == UNIT_I[u].cmp_b;      // RL9
            end
            if (!icr_top(UNIT_I[u].waveform_mode_sel)
                && UNIT_I[u].cap_evt)
            begin
                s_next.cap[u] = UNIT_I[u].counter;          // RL12
            end
        end
        // two-cycle access: decode, then answer
        case (s_reg.bus)
            timer16_irq_pkg::BUS_IDLE:
            begin
                if (req)
                begin
                    s_next.bus = timer16_irq_pkg::BUS_ACK;
                    if (idx == timer16_irq_pkg::IDX_T1_FLAGS)
                        s_next.rdata = s_reg.flags[0];
                    else if (idx == timer16_irq_pkg::IDX_T3_FLAGS)
                        s_next.rdata = s_reg.flags[1];
                    else if (idx == timer16_irq_pkg::IDX_T1_MASK)
                        s_next.rdata = s_reg.mask[0];
                    else if (idx == timer16_irq_pkg::IDX_T3_MASK)
                        s_next.rdata = s_reg.mask[1];
                    else
                        s_next.rdata = 8'h00;
                end
            end
            timer16_irq_pkg::BUS_ACK:
            begin
                s_next.bus = timer16_irq_pkg::BUS_IDLE;
            end
            default:
            begin
                s_next.bus = timer16_irq_pkg::BUS_IDLE;
            end
        endcase
    end

    // ***********************************************
    // state register
    // ***********************************************
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RESET_N_I)
        begin
            s_reg.bus    <= timer16_irq_pkg::BUS_IDLE;
            s_reg.rdata  <= 8'h00;
            s_reg.flags  <= {2{timer16_irq_pkg::FLAGS_RST}};
            s_reg.mask   <= {2{timer16_irq_pkg::MASK_RST}};
            s_reg.cap    <= '0;
            s_reg.pend_a <= '0;
            s_reg.pend_b <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ***********************************************
    // outputs
    // ***********************************************

    // requests are levels, the core samples them itself
    assign IRQ_REQ_O[0]      = req_of(s_reg.flags[0], s_reg.mask[0],
                                      GIE_I);               // RL1
    assign IRQ_REQ_O[1]      = req_of(s_reg.flags[1], s_reg.mask[1],
                                      GIE_I);               // RL1
    assign INT_O             = |IRQ_REQ_O;
    assign CAPTURE_REG_O     = s_reg.cap;
    assign AVS_READDATA_O    = {24'h00_0000, s_reg.rdata};  // RL2
    assign AVS_WAITREQUEST_O = req && !take;

    // ***********************************************
    // assertions
    // ***********************************************
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RESET_N_I);

    // helper: unit 1 matched on its last tick, kept apart from pend_a
    logic cmpa_armed;
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RESET_N_I)
            cmpa_armed <= 1'b0;
        else if (UNIT_I[0].tick)
            cmpa_armed <= UNIT_I[0].counter == UNIT_I[0].cmp_a;
    end

    sequence next_tick;
        UNIT_I[0].tick && cmpa_armed;
    endsequence

    int_gating_a: assert property ( // RL1
        INT_O |-> GIE_I && |(s_reg.flags[0] & s_reg.mask[0]
                             | s_reg.flags[1] & s_reg.mask[1]))
        else $error("interrupt raised without enabled flag");

    reserved_zero_a: assert property ( // RL2
        ((s_reg.flags[0] | s_reg.flags[1] | s_reg.mask[0] | s_reg.mask[1])
         & ~timer16_irq_pkg::IMPL_BITS) == 8'h00
        && AVS_READDATA_O[31:8] == 24'h00_0000)
        else $error("reserved bits not zero");

    capture_set_a: assert property ( // RL4
        UNIT_I[0].cap_evt && !icr_top(UNIT_I[0].waveform_mode_sel)
        |=> s_reg.flags[0][timer16_irq_pkg::CAPTURE_BIT])
        else $error("capture event did not set flag");

    capture_copy_a: assert property ( // RL12
        UNIT_I[0].cap_evt && !icr_top(UNIT_I[0].waveform_mode_sel)
        |=> CAPTURE_REG_O[0] == $past(UNIT_I[0].counter))
        else $error("capture register not loaded");

    icr_top_a: assert property ( // RL5
        icr_top(UNIT_I[0].waveform_mode_sel) && UNIT_I[0].tick
        && UNIT_I[0].counter == s_reg.cap[0]
        |=> s_reg.flags[0][timer16_irq_pkg::CAPTURE_BIT])
        else $error("top in capture mode did not set flag");

    vector_clear_a: assert property ( // RL6
        VEC_ACK_I[0][timer16_irq_pkg::OVF_BIT]
        && !set_v[0][timer16_irq_pkg::OVF_BIT]
        |=> !s_reg.flags[0][timer16_irq_pkg::OVF_BIT])
        else $error("vector did not clear flag");

    w1c_clear_a: assert property ( // RL7
        take && AVS_I.write && idx == timer16_irq_pkg::IDX_T3_FLAGS
        && wbyte[timer16_irq_pkg::CMPB_BIT]
        && !set_v[1][timer16_irq_pkg::CMPB_BIT]
        |=> !s_reg.flags[1][timer16_irq_pkg::CMPB_BIT])
        else $error("write one did not clear flag");

    w0_keep_a: assert property ( // RL8
        take && AVS_I.write && idx == timer16_irq_pkg::IDX_T1_FLAGS
        |=> ($past(s_reg.flags[0] & ~(wbyte | VEC_ACK_I[0]))
             & ~s_reg.flags[0]) == 8'h00)
        else $error("write zero disturbed flags");

    cmpa_delay_a: assert property ( // RL9
        next_tick
        |=> s_reg.flags[0][timer16_irq_pkg::CMPA_BIT])
        else $error("compare flag not set on next tick");

    cmpa_cause_a: assert property ( // RL10
        $rose(s_reg.flags[0][timer16_irq_pkg::CMPA_BIT])
        |-> $past(s_reg.pend_a[0] && UNIT_I[0].tick))
        else $error("compare flag set without a match");

    ovf_wrap_a: assert property ( // RL11
        wrap_mode(UNIT_I[0].waveform_mode_sel) && UNIT_I[0].tick
        && UNIT_I[0].counter == timer16_irq_pkg::COUNT_MAX
        |=> s_reg.flags[0][timer16_irq_pkg::OVF_BIT])
        else $error("overflow did not set flag");

    bus_answer_a: assert property (
        req && s_reg.bus == timer16_irq_pkg::BUS_IDLE
        |=> !AVS_WAITREQUEST_O)
        else $error("bus access not answered in one cycle");

endmodule

/* File: timer16_irq_pkg.sv */
package timer16_irq_pkg;

    // ***********************************************
    // flag and enable bit layout, shared by all regs
    // ***********************************************
    localparam int         CAPTURE_BIT = 5;
    localparam int         CMPB_BIT    = 2;
    localparam int         CMPA_BIT    = 1;
    localparam int         OVF_BIT     = 0;
    localparam logic [7:0] IMPL_BITS   = 8'h27;

    // ***********************************************
    // register indices, byte address is index * 4
    // ***********************************************
    localparam logic [7:0] IDX_T1_FLAGS = 8'h36;
    localparam logic [7:0] IDX_T3_FLAGS = 8'h38;
    localparam logic [7:0] IDX_T1_MASK  = 8'h6f;
    localparam logic [7:0] IDX_T3_MASK  = 8'h71;
    localparam logic [7:0] IDX_T1_CLR   = 8'h40;
    localparam logic [7:0] IDX_T3_CLR   = 8'h41;
    localparam int         ADDR_W       = 10;
    localparam int         IDX_LSB      = 2;

    // ***********************************************
    // reset values and counter constants
    // ***********************************************
    localparam logic [7:0]  FLAGS_RST = 8'h00;
    localparam logic [7:0]  MASK_RST  = 8'h00;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [3:0]  MODE_NORMAL  = 4'h0;
    localparam logic [3:0]  MODE_CTC_OCR = 4'h4;
    localparam logic [3:0]  MODE_CTC_ICR = 4'hc;
    localparam logic [3:0]  MODE_PC_ICR  = 4'h8;
    localparam logic [3:0]  MODE_PFC_ICR = 4'ha;
    localparam logic [3:0]  MODE_FST_ICR = 4'he;

    // ***********************************************
    // carriers
    // ***********************************************
    typedef struct packed {
        logic [15:0] counter;
        logic [15:0] cmp_a;
        logic [15:0] cmp_b;
        logic [3:0]  waveform_mode_sel;
        logic        tick;
        logic        cap_evt;
        logic        ovf_evt;
    } unit_in_t;

    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic              read;
        logic              write;
        logic [31:0]       writedata;
    } avs_req_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_t;

    typedef struct packed {
        bus_state_t        bus;
        logic [7:0]        rdata;
        logic [1:0][7:0]   flags;
        logic [1:0][7:0]   mask;
        logic [1:0][15:0]  cap;
        logic [1:0]        pend_a;
        logic [1:0]        pend_b;
    } state_t;

endpackage

/* File: core_model.sv */
// ********
// core side: takes one vector per request
// ********
module core_model #(
    parameter int LAT = 3
) (
    input  wire logic            clk_i,
    input  wire logic            en_i,
    input  wire logic [1:0][7:0] irq_i,
    output logic      [1:0][7:0] ack_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] pick;
    int          wait_cnt = 0;

    // lowest pending source wins, one vector at a time
    always_comb pick = irq_i & (~irq_i + 16'h0001);

    // counts 0 to LAT before every answer, so each answer comes equally late
    always @(posedge clk_i)
    begin
        ack_o <= '0;
        if (en_i && (|irq_i))
        begin
            wait_cnt <= (wait_cnt == LAT) ? 0 : wait_cnt + 1;
            if (wait_cnt == LAT)
                ack_o <= pick;
        end
        else
            wait_cnt <= 0;
    end
endmodule

/* File: timer16_irq_flag_mask_bench.sv */
module timer16_irq_flag_mask_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic                            clk;
    logic                            rst_n;
    logic                            gie;
    logic                            ack_en;
    timer16_irq_pkg::avs_req_t       req;
    timer16_irq_pkg::unit_in_t [1:0] units;
    logic [1:0][7:0]                 vec_ack;
    logic [1:0][7:0]                 irq;
    logic [1:0][15:0]                cap_reg;
    logic [31:0]                     rdata;
    logic                            wait_req;
    logic                            int_o;
    logic [1:0][7:0] fl = {timer16_irq_pkg::IDX_T3_FLAGS,
                           timer16_irq_pkg::IDX_T1_FLAGS};
    logic [1:0][7:0] mk = {timer16_irq_pkg::IDX_T3_MASK,
                           timer16_irq_pkg::IDX_T1_MASK};
    logic [1:0][7:0] cl = {timer16_irq_pkg::IDX_T3_CLR,
                           timer16_irq_pkg::IDX_T1_CLR};
    int n_fail = 0;
    int samples_checked = 0;

    always #25 clk = ~clk;

    timer16_irq uut (
        .REF_CLK_I(clk), .RESET_N_I(rst_n), .AVS_I(req),
        .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_req),
        .UNIT_I(units), .VEC_ACK_I(vec_ack), .GIE_I(gie),
        .IRQ_REQ_O(irq), .CAPTURE_REG_O(cap_reg), .INT_O(int_o));

    core_model #(.LAT(3)) core (
        .clk_i(clk), .en_i(ack_en), .irq_i(irq), .ack_o(vec_ack));

    // ********
    // shared helpers
    // ********
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // request held until the edge that sees waitrequest low; data and
    // release at that edge only, the watchdog ends a hung wait
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd, output logic [7:0] rd);
        @(posedge clk);
        req.address <= {idx, 2'b00};
        req.read <= !wr;
        req.write <= wr;
        req.writedata <= {24'h00_0000, wd};
        @(posedge clk);
        while (wait_req !== 1'b0)
            @(posedge clk);
        rd = rdata[7:0];
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, idx, d, x);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] x;
        bus(1'b0, idx, 8'h00, x);
        chk(32'(x), 32'(exp));
    endtask

    // one-cycle event on a unit, returns where the flag is visible
    task automatic ev(input int u, input logic [15:0] cnt,
                      input logic t, input logic c, input logic o);
        @(posedge clk);
        units[u].counter <= cnt;
        units[u].tick <= t;
        units[u].cap_evt <= c;
        units[u].ovf_evt <= o;
        @(posedge clk);
        units[u].tick <= 1'b0;
        units[u].cap_evt <= 1'b0;
        units[u].ovf_evt <= 1'b0;
        @(negedge clk);
    endtask

    task automatic mode(input int u, input logic [3:0] m);
        @(posedge clk);
        units[u].waveform_mode_sel <= m;
    endtask

    // ********
    // scenarios
    // ********
    task automatic t_regs;
        rd_chk(8'h00, 8'h00);
        for (int u = 0; u < 2; u++)
        begin
            rd_chk(fl[u], timer16_irq_pkg::FLAGS_RST);
            rd_chk(mk[u], timer16_irq_pkg::MASK_RST);
            wr(mk[u], 8'hff);
            rd_chk(mk[u], 8'h27);
            wr(mk[u], 8'h00);
            rd_chk(cl[u], 8'h00);
        end
    endtask

    task automatic t_capture;
        for (int u = 0; u < 2; u++)
        begin
            ev(u, 16'h1234 + 16'(u), 1'b0, 1'b1, 1'b0);
            chk(32'(cap_reg[u]), 32'(16'h1234 + 16'(u)));
            rd_chk(fl[u], 8'h20);
            wr(fl[u], 8'hdf);
            rd_chk(fl[u], 8'h20);
            wr(fl[u], 8'h20);
            rd_chk(fl[u], 8'h00);
        end
    endtask

    // match is stored on one tick and shown on the next
    task automatic t_compare;
        for (int u = 0; u < 2; u++)
        begin
            @(posedge clk);
            units[u].cmp_a <= 16'h0100;
            units[u].cmp_b <= 16'h0200;
            ev(u, 16'h0100, 1'b1, 1'b0, 1'b0);
            rd_chk(fl[u], 8'h00);
            ev(u, 16'h0101, 1'b1, 1'b0, 1'b0);
            rd_chk(fl[u], 8'h02);
            ev(u, 16'h0200, 1'b1, 1'b0, 1'b0);
            ev(u, 16'h0201, 1'b1, 1'b0, 1'b0);
            rd_chk(fl[u], 8'h06);
            wr(cl[u], 8'h02);
            rd_chk(fl[u], 8'h04);
            wr(fl[u], 8'h04);
            rd_chk(fl[u], 8'h00);
        end
    endtask

    task automatic t_ovf;
        logic [1:0][3:0] md = {timer16_irq_pkg::MODE_CTC_OCR,
                               timer16_irq_pkg::MODE_NORMAL};
        for (int u = 0; u < 2; u++)
        begin
            for (int k = 0; k < 2; k++)
            begin
                mode(u, md[k]);
                ev(u, 16'hffff, 1'b1, 1'b0, 1'b0);
                rd_chk(fl[u], 8'h01);
                wr(fl[u], 8'h01);
            end
            mode(u, timer16_irq_pkg::MODE_PC_ICR);
            ev(u, 16'h0000, 1'b0, 1'b0, 1'b1);
            rd_chk(fl[u], 8'h01);
            wr(fl[u], 8'h01);
            mode(u, timer16_irq_pkg::MODE_CTC_ICR);
            ev(u, 16'h5555, 1'b0, 1'b1, 1'b0);
            chk(32'(cap_reg[u]), 32'(16'h1234 + 16'(u)));
            rd_chk(fl[u], 8'h00);
            ev(u, 16'h1234 + 16'(u), 1'b1, 1'b0, 1'b0);
            rd_chk(fl[u], 8'h20);
            wr(fl[u], 8'h20);
            mode(u, timer16_irq_pkg::MODE_NORMAL);
        end
    endtask

    // unit 3 stays masked so the core must leave its flag alone
    task automatic t_irq;
        int n;
        wr(mk[0], 8'h21);
        ev(0, 16'h0010, 1'b0, 1'b1, 1'b0);
        ev(0, 16'hffff, 1'b1, 1'b0, 1'b0);
        ev(1, 16'hffff, 1'b1, 1'b0, 1'b0);
        chk(32'(irq), 32'h0000_0000);
        chk(32'(int_o), 32'h0000_0000);
        @(posedge clk);
        gie <= 1'b1;
        @(negedge clk);
        chk(32'(irq), 32'h0000_0021);
        chk(32'(int_o), 32'h0000_0001);
        @(posedge clk);
        ack_en <= 1'b1;
        n = 0;
        while (irq[0] !== 8'h00 && n < 40)
        begin
            n++;
            @(negedge clk);
        end
        chk(32'(irq), 32'h0000_0000);
        @(posedge clk);
        ack_en <= 1'b0;
        rd_chk(fl[0], 8'h00);
        rd_chk(fl[1], 8'h01);
        wr(cl[1], 8'h01);
        rd_chk(fl[1], 8'h00);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // watchdog sized well above the run of all scenarios
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        test_done();
    end

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        gie = 1'b0;
        ack_en = 1'b0;
        req = '0;
        units = '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_capture();
        t_compare();
        t_ovf();
        t_irq();
        test_done();
    end
endmodule
